// *** design/codec_cfg_pkg.sv ***
// Purpose: Constants, types and helpers for the codec clock, channel and rate configuration bank.
// Assumes: APB slave, 32-bit data, one register per aligned word at byte address index times 4.
// Notes: Registers are 8 bits wide in the low byte, and the upper bits read as zero.
//
// How it works
// - Primary override off follows role select
// - Primary override: select picks bit clock direction
// - Secondary override off follows role select
// - Secondary override: select picks bit clock direction
// - Primary controller: bit 2 picks internal sync
// - Secondary controller: bit 1 picks internal sync
// - ADC force bit picks custom mask source
// - ADC mask bits 6..3 enable channels 4..1
// - DAC force bit picks custom mask source
// - DAC mask bits enable channels 4..1
// - Bit 7 enables the rate converter
// - Bit 6 disables automatic rate detection
// - Custom bit selects manual main rate
// - Manual main rate: primary or secondary
// - Numerator field: zero auto, 5 and 7 reserved
// - Denominator field: zero auto, 5 and 7 reserved
package codec_cfg_pkg;

   ////////////////////////////////////////////////////////////////////////////////////////////
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int REG_W = 8;

   // Register indices as printed; the byte address is the index times four.
   localparam logic [5:0] IDX_CLOCK_PORT_ROLE = 6'h0d;
   localparam logic [5:0] IDX_ADC_CHAN_MASK = 6'h0e;
   localparam logic [5:0] IDX_DAC_CHAN_MASK = 6'h0f;
   localparam logic [5:0] IDX_RATE_CONTROL = 6'h17;
   localparam logic [5:0] IDX_RATE_RATIO = 6'h18;

   localparam logic [7:0] RST_CLOCK_PORT_ROLE = 8'h00;
   localparam logic [7:0] RST_ADC_CHAN_MASK = 8'h00;
   localparam logic [7:0] RST_DAC_CHAN_MASK = 8'h00;
   localparam logic [7:0] RST_RATE_CONTROL = 8'h00;
   localparam logic [7:0] RST_RATE_RATIO = 8'h00;

   // Writable bits; all others are read-only and keep their reset value.
   localparam logic [7:0] WMASK_CLOCK_PORT_ROLE = 8'hdf;
   localparam logic [7:0] WMASK_ADC_CHAN_MASK = 8'hf8;
   localparam logic [7:0] WMASK_DAC_CHAN_MASK = 8'hf8;
   localparam logic [7:0] WMASK_RATE_CONTROL = 8'hc0;
   localparam logic [7:0] WMASK_RATE_RATIO = 8'hff;

   // Field positions.
   localparam int POS_PRIMARY_OVERRIDE = 7;
   localparam int POS_SECONDARY_OVERRIDE = 6;
   localparam int POS_PRIMARY_INT_SYNC = 2;
   localparam int POS_SECONDARY_INT_SYNC = 1;
   localparam int POS_FORCE_CUSTOM = 7;
   localparam int POS_MASK_LSB = 3;
   localparam int POS_CONVERTER_ENABLE = 7;
   localparam int POS_AUTODETECT_DISABLE = 6;
   localparam int POS_MAIN_RATE_CUSTOM = 7;
   localparam int POS_MAIN_RATE_SELECT = 6;
   localparam int POS_NUMERATOR_LSB = 3;
   localparam int POS_DENOMINATOR_LSB = 0;

   localparam logic [2:0] RATIO_AUTO = 3'h0;
   localparam logic [2:0] RATIO_RSVD_A = 3'h5;
   localparam logic [2:0] RATIO_RSVD_B = 3'h7;

   ////////////////////////////////////////////////////////////////////////////////////////////
   typedef enum logic {PH_IDLE = 1'b0, PH_ANSWER = 1'b1} apb_phase_t;

   typedef struct packed {
      logic override;
      logic controller;
      logic bclk_drive;
      logic frame_sync_drive;
      logic autodetect_avail;
      logic internal_frame_sync;
   } port_role_t;

   typedef struct packed {
      logic from_custom;
      logic [3:0] enable;
   } chan_ctl_t;

   typedef struct packed {
      logic enable;
      logic autodetect_en;
      logic manual;
      logic from_secondary;
   } rate_ctl_t;

   typedef struct packed {
      logic auto_infer;
      logic [2:0] value;
      logic reserved;
   } ratio_t;

   typedef struct packed {
      apb_phase_t phase;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
      logic [7:0] clock_port_role_config;
      logic [7:0] adc_channel_mask_config;
      logic [7:0] dac_channel_mask_config;
      logic [7:0] rate_converter_control;
      logic [7:0] rate_converter_ratio;
      port_role_t primary;
      port_role_t secondary;
      chan_ctl_t adc;
      chan_ctl_t dac;
      rate_ctl_t rate;
      ratio_t numerator;
      ratio_t denominator;
   } cfg_state_t;

   localparam port_role_t ROLE_RST = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
   localparam chan_ctl_t CHAN_RST = '{1'b0, 4'h0};
   localparam rate_ctl_t RATE_RST = '{1'b0, 1'b1, 1'b0, 1'b0};
   localparam ratio_t RATIO_RST = '{1'b1, 3'h0, 1'b0};

   localparam cfg_state_t STATE_RST = '{PH_IDLE, 1'b0, 1'b0, 32'h0000_0000,
      RST_CLOCK_PORT_ROLE, RST_ADC_CHAN_MASK, RST_DAC_CHAN_MASK, RST_RATE_CONTROL,
      RST_RATE_RATIO, ROLE_RST, ROLE_RST, CHAN_RST, CHAN_RST, RATE_RST, RATIO_RST, RATIO_RST};

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Pin roles of one serial port from its override, role select and internal sync bits.
   function automatic port_role_t role_decode(input logic override, input logic select,
                                              input logic int_sync);
      port_role_t r;
      r.override = override;
      r.controller = select & ~override;
      if (override)
      begin
         r.bclk_drive = select;
         r.frame_sync_drive = ~select;
         r.autodetect_avail = 1'b0;
      end
      else
      begin
         r.bclk_drive = select;
         r.frame_sync_drive = select;
         r.autodetect_avail = 1'b1;
      end
      // The sync source choice only means something while the port is a controller.
      r.internal_frame_sync = r.controller & int_sync;
      return r;
   endfunction : role_decode

   // Channel enables: either the custom mask or the lowest select+1 channels.
   function automatic chan_ctl_t chan_decode(input logic force_custom, input logic [3:0] mask,
                                             input logic [1:0] max_sel);
      chan_ctl_t c;
      c.from_custom = force_custom;
      case (max_sel)
         2'h0: c.enable = 4'h1;
         2'h1: c.enable = 4'h3;
         2'h2: c.enable = 4'h7;
         default: c.enable = 4'hf;
      endcase
      if (force_custom)
      begin
         c.enable = mask;
      end
      return c;
   endfunction : chan_decode

   function automatic ratio_t ratio_decode(input logic [2:0] code);
      ratio_t q;
      q.auto_infer = (code == RATIO_AUTO);
      q.value = code;
      q.reserved = (code == RATIO_RSVD_A) || (code == RATIO_RSVD_B);
      return q;
   endfunction : ratio_decode

endpackage : codec_cfg_pkg

// *** design/codec_cfg_regs.sv ***
// Purpose: APB register bank for serial port roles, channel masks and rate converter setup.
// Assumes: Single clock; role select and max channel select come from logic on this clock.
// Notes: The answer comes in the first access cycle; unmapped or misaligned addresses get pslverr.
`timescale 1ns/1ps

module codec_cfg_regs
   import codec_cfg_pkg::*;
(
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [ADDR_W-1:0] paddr_i,
   input wire logic [DATA_W-1:0] pwdata_i,
   input wire logic [3:0] pstrb_i,
   input wire logic primary_role_select_i,
   input wire logic secondary_role_select_i,
   input wire logic [1:0] adc_max_chan_select_i,
   input wire logic [1:0] dac_max_chan_select_i,
   output logic pready_o,
   output logic pslverr_o,
   output logic [DATA_W-1:0] prdata_o,
   output port_role_t primary_role_o,
   output port_role_t secondary_role_o,
   output chan_ctl_t adc_chan_o,
   output chan_ctl_t dac_chan_o,
   output rate_ctl_t rate_ctl_o,
   output ratio_t ratio_numerator_o,
   output ratio_t ratio_denominator_o
);

   ////////////////////////////////////////////////////////////////////////////////////////////
   cfg_state_t st;
   cfg_state_t next_st;
   logic [5:0] idx;
   logic aligned;
   logic hit;
   logic [7:0] rd_value;
   logic [7:0] wbyte;

   assign idx = paddr_i[7:2];
   assign aligned = (paddr_i[1:0] == 2'h0);
   assign wbyte = pwdata_i[7:0];

   // Address decode and read mux.
   always_comb
   begin
      hit = aligned;
      rd_value = 8'h00;
      case (idx)
         IDX_CLOCK_PORT_ROLE: rd_value = st.clock_port_role_config;
         IDX_ADC_CHAN_MASK: rd_value = st.adc_channel_mask_config;
         IDX_DAC_CHAN_MASK: rd_value = st.dac_channel_mask_config;
         IDX_RATE_CONTROL: rd_value = st.rate_converter_control;
         IDX_RATE_RATIO: rd_value = st.rate_converter_ratio;
         default: hit = 1'b0;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   always_comb
   begin
      next_st = st;
      case (st.phase)
         PH_IDLE:
         begin
            if (psel_i && !penable_i)
            begin
               next_st.phase = PH_ANSWER;
               next_st.pready = 1'b1;
               next_st.pslverr = ~hit;
               next_st.prdata = (hit && !pwrite_i) ? {24'h00_0000, rd_value} : 32'h0000_0000;
            end
         end
         PH_ANSWER:
         begin
            // The write lands at the edge where the master sees pready high.
            if (psel_i && penable_i && pwrite_i && hit && pstrb_i[0])
            begin
               // Read-only bits are masked so they keep their reset value.
               case (idx)
                  IDX_CLOCK_PORT_ROLE:
                     next_st.clock_port_role_config = (st.clock_port_role_config &
                        ~WMASK_CLOCK_PORT_ROLE) | (wbyte & WMASK_CLOCK_PORT_ROLE);
                  IDX_ADC_CHAN_MASK:
                     next_st.adc_channel_mask_config = (st.adc_channel_mask_config &
                        ~WMASK_ADC_CHAN_MASK) | (wbyte & WMASK_ADC_CHAN_MASK);
                  IDX_DAC_CHAN_MASK:
                     next_st.dac_channel_mask_config = (st.dac_channel_mask_config &
                        ~WMASK_DAC_CHAN_MASK) | (wbyte & WMASK_DAC_CHAN_MASK);
                  IDX_RATE_CONTROL:
                     next_st.rate_converter_control = (st.rate_converter_control &
                        ~WMASK_RATE_CONTROL) | (wbyte & WMASK_RATE_CONTROL);
                  IDX_RATE_RATIO:
                     next_st.rate_converter_ratio = (st.rate_converter_ratio &
                        ~WMASK_RATE_RATIO) | (wbyte & WMASK_RATE_RATIO);
                  default:
                     next_st.rate_converter_ratio = st.rate_converter_ratio;
               endcase
            end
            next_st.phase = PH_IDLE;
            next_st.pready = 1'b0;
            next_st.pslverr = 1'b0;
            next_st.prdata = 32'h0000_0000;
         end
         default:
         begin
            next_st.phase = PH_IDLE;
            next_st.pready = 1'b0;
         end
      endcase

      // Decoded controls follow the registers in the same edge as the write.
      // Reserved bits 4..3 and 0 are stored but steer nothing; software keeps them at reset.
      next_st.primary = role_decode(
         next_st.clock_port_role_config[POS_PRIMARY_OVERRIDE], primary_role_select_i,
         next_st.clock_port_role_config[POS_PRIMARY_INT_SYNC]);
      next_st.secondary = role_decode(
         next_st.clock_port_role_config[POS_SECONDARY_OVERRIDE], secondary_role_select_i,
         next_st.clock_port_role_config[POS_SECONDARY_INT_SYNC]);
      next_st.adc = chan_decode(next_st.adc_channel_mask_config[POS_FORCE_CUSTOM],
         next_st.adc_channel_mask_config[POS_MASK_LSB +: 4], adc_max_chan_select_i);
      next_st.dac = chan_decode(next_st.dac_channel_mask_config[POS_FORCE_CUSTOM],
         next_st.dac_channel_mask_config[POS_MASK_LSB +: 4], dac_max_chan_select_i);
      next_st.rate.enable = next_st.rate_converter_control[POS_CONVERTER_ENABLE];
      next_st.rate.autodetect_en = ~next_st.rate_converter_control[POS_AUTODETECT_DISABLE];
      next_st.rate.manual = next_st.rate_converter_ratio[POS_MAIN_RATE_CUSTOM];
      // Without manual mode the select bit is ignored and the rate is inferred.
      next_st.rate.from_secondary = next_st.rate_converter_ratio[POS_MAIN_RATE_CUSTOM] &
         next_st.rate_converter_ratio[POS_MAIN_RATE_SELECT];
      next_st.numerator = ratio_decode(
         next_st.rate_converter_ratio[POS_NUMERATOR_LSB +: 3]);
      next_st.denominator = ratio_decode(
         next_st.rate_converter_ratio[POS_DENOMINATOR_LSB +: 3]);
   end

   always_ff @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         st <= STATE_RST;
      end
      else
      begin
         st <= next_st;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   assign pready_o = st.pready;
   assign pslverr_o = st.pslverr;
   assign prdata_o = st.prdata;
   assign primary_role_o = st.primary;
   assign secondary_role_o = st.secondary;
   assign adc_chan_o = st.adc;
   assign dac_chan_o = st.dac;
   assign rate_ctl_o = st.rate;
   assign ratio_numerator_o = st.numerator;
   assign ratio_denominator_o = st.denominator;

endmodule : codec_cfg_regs

// *** verif/codec_cfg_regs_assertions.sv ***
// Purpose: Port checker for the codec clock, channel and rate configuration bank.
// Assumes: One clock domain; decoded outputs register their inputs one edge late.
// Notes: Input-tracking checks skip the first edge after reset, when outputs still hold reset.
`timescale 1ns/1ps

module codec_cfg_regs_assertions
   import codec_cfg_pkg::*;
(
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic primary_role_select_i,
   input wire logic secondary_role_select_i,
   input wire logic [1:0] adc_max_chan_select_i,
   input wire logic [1:0] dac_max_chan_select_i,
   input wire logic pready_o,
   input wire logic pslverr_o,
   input wire logic [DATA_W-1:0] prdata_o,
   input wire port_role_t primary_role_o,
   input wire port_role_t secondary_role_o,
   input wire chan_ctl_t adc_chan_o,
   input wire chan_ctl_t dac_chan_o,
   input wire rate_ctl_t rate_ctl_o,
   input wire ratio_t ratio_numerator_o,
   input wire ratio_t ratio_denominator_o
);
   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (rst_i);

   ////////////////////////////////////////////////////////////////////////////////////////////
   a_ready_pulse: assert property (pready_o |=> !pready_o)
      else $error("pready stayed high past one cycle");
   a_ready_after_setup: assert property (psel_i && !penable_i |=> pready_o)
      else $error("no answer in the cycle after setup");
   a_error_with_ready: assert property (pslverr_o |-> pready_o)
      else $error("pslverr without pready");
   a_idle_data_zero: assert property (
      prdata_o[31:8] == 24'h0 && (pready_o || prdata_o == 32'h0))
      else $error("read data nonzero outside answer or above bit 7");
   a_primary_bclk: assert property (
      !$past(rst_i) |-> primary_role_o.bclk_drive == $past(primary_role_select_i))
      else $error("primary bit clock direction does not follow select");
   a_primary_override: assert property (
      primary_role_o.override |-> !primary_role_o.autodetect_avail &&
      primary_role_o.frame_sync_drive != primary_role_o.bclk_drive)
      else $error("primary override pin roles wrong");
   a_primary_follow: assert property (
      !primary_role_o.override |-> primary_role_o.autodetect_avail &&
      primary_role_o.frame_sync_drive == primary_role_o.bclk_drive &&
      primary_role_o.controller == primary_role_o.bclk_drive)
      else $error("primary standard pin roles wrong");
   a_secondary_roles: assert property (
      !$past(rst_i) |-> secondary_role_o.bclk_drive == $past(secondary_role_select_i) &&
      (secondary_role_o.override ?
      (!secondary_role_o.autodetect_avail &&
      secondary_role_o.frame_sync_drive != secondary_role_o.bclk_drive) :
      (secondary_role_o.autodetect_avail &&
      secondary_role_o.frame_sync_drive == secondary_role_o.bclk_drive)))
      else $error("secondary pin roles wrong");
   a_sync_controller: assert property (
      (!primary_role_o.internal_frame_sync || primary_role_o.controller) &&
      (!secondary_role_o.internal_frame_sync || secondary_role_o.controller))
      else $error("internal sync outside controller mode");
   a_adc_default: assert property (
      !$past(rst_i) && !adc_chan_o.from_custom |-> adc_chan_o.enable ==
      {$past(adc_max_chan_select_i) == 2'h3, $past(adc_max_chan_select_i) >= 2'h2,
      $past(adc_max_chan_select_i) != 2'h0, 1'b1})
      else $error("adc enables do not follow max select");
   a_dac_default: assert property (
      !$past(rst_i) && !dac_chan_o.from_custom |-> dac_chan_o.enable ==
      {$past(dac_max_chan_select_i) == 2'h3, $past(dac_max_chan_select_i) >= 2'h2,
      $past(dac_max_chan_select_i) != 2'h0, 1'b1})
      else $error("dac enables do not follow max select");
   a_numerator_codes: assert property (
      ratio_numerator_o.auto_infer == (ratio_numerator_o.value == 3'h0) &&
      ratio_numerator_o.reserved ==
      (ratio_numerator_o.value == 3'h5 || ratio_numerator_o.value == 3'h7))
      else $error("numerator flags wrong");
   a_denominator_codes: assert property (
      ratio_denominator_o.auto_infer == (ratio_denominator_o.value == 3'h0) &&
      ratio_denominator_o.reserved ==
      (ratio_denominator_o.value == 3'h5 || ratio_denominator_o.value == 3'h7))
      else $error("denominator flags wrong");
   a_rate_source: assert property (rate_ctl_o.from_secondary |-> rate_ctl_o.manual)
      else $error("secondary rate chosen while not manual");
   c_error: cover property (pslverr_o);
   c_override: cover property (primary_role_o.override && primary_role_o.bclk_drive);
   c_custom: cover property (adc_chan_o.from_custom && dac_chan_o.from_custom);
endmodule : codec_cfg_regs_assertions

bind codec_cfg_regs codec_cfg_regs_assertions codec_cfg_regs_assertions_i (.mclk_i(mclk_i),
   .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
   .primary_role_select_i(primary_role_select_i),
   .secondary_role_select_i(secondary_role_select_i),
   .adc_max_chan_select_i(adc_max_chan_select_i), .dac_max_chan_select_i(dac_max_chan_select_i),
   .pready_o(pready_o), .pslverr_o(pslverr_o), .prdata_o(prdata_o),
   .primary_role_o(primary_role_o), .secondary_role_o(secondary_role_o),
   .adc_chan_o(adc_chan_o), .dac_chan_o(dac_chan_o), .rate_ctl_o(rate_ctl_o),
   .ratio_numerator_o(ratio_numerator_o), .ratio_denominator_o(ratio_denominator_o));

// *** verif/codec_cfg_regs_tb.sv ***
// Purpose: Self-checking bench for the codec configuration bank over APB.
// Assumes: Decoded outputs settle by the idle edge that ends each transfer task.
// Notes: Transfers are separated by one idle cycle, so back-to-back access is not exercised.
`timescale 1ns/1ps

module codec_cfg_regs_tb import codec_cfg_pkg::*;;
   logic mclk_i;
   logic rst_i = 1'b1;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, prs = 1'b0, srs = 1'b0;
   logic pready, pslverr, err;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [3:0] pstrb = 4'hf;
   logic [1:0] amx = 2'h0, dmx = 2'h0;
   port_role_t prole, srole;
   chan_ctl_t adc, dac;
   rate_ctl_t rate;
   ratio_t num, den;
   int miscompares = 0, checked = 0, cycles = 0;
   logic [7:0] addrs [5] = '{8'h34, 8'h38, 8'h3c, 8'h5c, 8'h60};
   // Functional bits only; reserved bits are always written with their reset value.
   logic [7:0] wval [5] = '{8'hc6, 8'hf8, 8'hf8, 8'hc0, 8'hff};

   codec_cfg_regs codec_cfg_regs_i (.mclk_i(mclk_i), .rst_i(rst_i), .psel_i(psel),
      .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
      .pstrb_i(pstrb), .primary_role_select_i(prs), .secondary_role_select_i(srs),
      .adc_max_chan_select_i(amx), .dac_max_chan_select_i(dmx), .pready_o(pready),
      .pslverr_o(pslverr), .prdata_o(prdata), .primary_role_o(prole),
      .secondary_role_o(srole), .adc_chan_o(adc), .dac_chan_o(dac), .rate_ctl_o(rate),
      .ratio_numerator_o(num), .ratio_denominator_o(den));

   ////////////////////////////////////////////////////////////////////////////////////////////
   task automatic final_report();
      $display("checked=%0d miscompares=%0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : final_report

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask : check

   // The request is held until pready is seen high; the wait is bounded by the bench timeout.
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk_i);
      penable <= 1'b1;
      do
         @(posedge mclk_i);
      while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge mclk_i);
   endtask : xfer

   function automatic logic [5:0] role_exp(input logic ov, input logic s, input logic is);
      return {ov, s & ~ov, s, ov ? ~s : s, ~ov, s & ~ov & is};
   endfunction : role_exp

   function automatic logic [3:0] therm(input logic [1:0] s);
      return {s == 2'h3, s >= 2'h2, s != 2'h0, 1'b1};
   endfunction : therm

   ////////////////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      mclk_i = 1'b0;
      forever #2.5 mclk_i = ~mclk_i;
   end

   always @(posedge mclk_i)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         miscompares++;
         final_report();
      end
   end

   initial
   begin
      logic [3:0] m;
      logic [2:0] code;
      repeat (3) @(posedge mclk_i);
      rst_i <= 1'b0;
      @(posedge mclk_i);
      for (int i = 0; i < 5; i++)
      begin
         xfer(1'b0, addrs[i], 32'h0);
         check(rd, 32'h0);
         xfer(1'b1, addrs[i], {24'hff_ffff, wval[i]});
         xfer(1'b0, addrs[i], 32'h0);
         check(rd, {24'h0, wval[i]});
      end
      $display("test register map done");
      xfer(1'b0, 8'h40, 32'h0);
      check(32'(err), 32'h1);
      check(rd, 32'h0);
      xfer(1'b1, 8'h35, 32'h0);
      check(32'(err), 32'h1);
      pstrb <= 4'h0;
      xfer(1'b1, 8'h60, 32'h5a);
      pstrb <= 4'hf;
      xfer(1'b0, 8'h34, 32'h0);
      check(rd, 32'hc6);
      xfer(1'b0, 8'h60, 32'h0);
      check(rd, 32'hff);
      $display("test refusals done");
      for (int c = 0; c < 8; c++)
      begin
         prs <= c[0];
         srs <= ~c[0];
         xfer(1'b1, 8'h34, {24'h0, c[1], c[1], 3'h0, c[2], c[2], 1'b0});
         check(32'(prole), 32'(role_exp(c[1], c[0], c[2])));
         check(32'(srole), 32'(role_exp(c[1], ~c[0], c[2])));
      end
      $display("test port roles done");
      for (int c = 0; c < 8; c++)
      begin
         m = {c[1:0], ~c[1:0]};
         amx <= c[1:0];
         dmx <= ~c[1:0];
         xfer(1'b1, 8'h38, {24'h0, c[2], m, 3'h0});
         xfer(1'b1, 8'h3c, {24'h0, ~c[2], ~m, 3'h0});
         check(32'(adc), {27'h0, c[2], c[2] ? m : therm(c[1:0])});
         check(32'(dac), {27'h0, ~c[2], c[2] ? therm(~c[1:0]) : ~m});
      end
      $display("test channel masks done");
      for (int c = 0; c < 8; c++)
      begin
         code = c[2:0];
         xfer(1'b1, 8'h5c, {24'h0, c[1], c[2], 6'h0});
         xfer(1'b1, 8'h60, {24'h0, c[0], c[1], code, ~code});
         check(32'(rate), {28'h0, c[1], ~c[2], c[0], c[0] & c[1]});
         check(32'(num), {27'h0, code == 3'h0, code, code == 3'h5 || code == 3'h7});
         check(32'(den), {27'h0, code == 3'h7, ~code, code == 3'h2 || code == 3'h0});
      end
      $display("test rate converter done");
      // A second reset in mid-run must bring the rate control register and the rate, numerator and primary role outputs back.
      rst_i <= 1'b1;
      @(posedge mclk_i);
      check(32'(rate), 32'h4);
      check(32'(num), 32'h10);
      check(32'(prole), 32'h2);
      rst_i <= 1'b0;
      @(posedge mclk_i);
      xfer(1'b0, 8'h5c, 32'h0);
      check(rd, 32'h0);
      $display("test reset done");
      final_report();
   end
endmodule : codec_cfg_regs_tb
